// ### pmr_regs.svh
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

// Register addresses
`define PMR_ADDR_W             8
`define PMR_RMS_VOLTAGE_CURRENT 8'h20
`define PMR_ACTIVE_REACTIVE    8'h21
`define PMR_APPARENT_FACTOR    8'h22
`define PMR_RMS_SAMPLE_COUNT   8'h25
`define PMR_RMS_AVG_FIRST      8'h26
`define PMR_RMS_AVG_SECOND     8'h27
`define PMR_REAL_AVG_FIRST     8'h28
`define PMR_REAL_AVG_SECOND    8'h29

// Field positions (low bit of each field)
`define PMR_LO_FIELD_LSB       0
`define PMR_HI_FIELD_LSB       16
`define PMR_RATIO_LSB          16
`define PMR_ANGLE_SIGN_BIT     27
`define PMR_RATIO_SIGN_BIT     28
`define PMR_COUNT_LSB          0

// Field widths
`define PMR_HALF_W             16
`define PMR_RATIO_W            11
`define PMR_COUNT_W            10
`define PMR_AVG_LEN_W          7

// Reset and unmapped read values
`define PMR_RESULT_RESET       32'h0000_0000
`define PMR_UNMAPPED_DATA      32'h0000_0000

`endif

// ### pmr_pkg.sv
package pmr_pkg;

    // Latched measurement results and register port state of the top
    typedef struct packed {
        logic [15:0] rms_volts;
        logic [15:0] rms_amps;
        logic [15:0] real_power;
        logic [15:0] reactive_power;
        logic [15:0] apparent_power;
        logic [10:0] power_ratio;
        logic        angle_sign;
        logic        ratio_sign;
        logic [31:0] rd_data;
        logic        rd_valid;
        logic        rd_miss;
        logic        wr_dropped;
    } pmr_top_state_t;

    // Selects which RMS channel the averagers follow
    typedef enum logic {
        PMR_AVG_VOLTS = 1'b0,
        PMR_AVG_AMPS  = 1'b1
    } pmr_avg_sel_t;

endpackage : pmr_pkg

// ### pmr_avg.sv
`timescale 1ns/100ps
`include "pmr_regs.svh"

module pmr_avg
    import pmr_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int LEN_W  = 7,
    parameter bit SIGNED = 1'b0
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // Sample stream
    input  wire logic              sample_en,
    input  wire logic [DATA_W-1:0] sample,
    input  wire logic [LEN_W-1:0]  avg_len,
    // Result
    output logic      [DATA_W-1:0] avg
);

    localparam int ACC_W = DATA_W + LEN_W + 1;

    typedef struct packed {
        logic [ACC_W-1:0]  acc;
        logic [LEN_W-1:0]  cnt;
        logic [DATA_W-1:0] avg;
    } pmr_avg_state_t;

    pmr_avg_state_t st;
    pmr_avg_state_t next_st;
    logic [ACC_W-1:0] ext;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] len_eff;
    logic [ACC_W-1:0] quot;

    // Sign or zero extend, length zero acts as one
    always_comb begin
        ext     = SIGNED ? {{(LEN_W+1){sample[DATA_W-1]}}, sample}
                         : {{(LEN_W+1){1'b0}}, sample};
        sum     = st.acc + ext;
        len_eff = (avg_len == '0) ? ACC_W'(1) : ACC_W'(avg_len);
        quot    = SIGNED ? ACC_W'($signed(sum) / $signed(len_eff)) : sum / len_eff;
    end

    // Accumulate a block of samples and publish the mean at its end
    always_comb begin
        next_st = st;
        if (sample_en) begin
            if (ACC_W'(st.cnt) + ACC_W'(1) >= len_eff) begin
                next_st.avg = quot[DATA_W-1:0];
                next_st.acc = '0;
                next_st.cnt = '0;
            end else begin
                next_st.acc = sum;
                next_st.cnt = st.cnt + LEN_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign avg = st.avg;

endmodule : pmr_avg

// ### pmr_count.sv
`timescale 1ns/100ps
`include "pmr_regs.svh"

module pmr_count
    import pmr_pkg::*;
#(
    parameter int CNT_W = 10
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Sample ticks and full-cycle voltage crossings
    input  wire logic             sample_tick,
    input  wire logic             cycle_mark,
    // Count of samples in the last full cycle
    output logic      [CNT_W-1:0] count
);

    typedef struct packed {
        logic [CNT_W-1:0] run;
        logic [CNT_W-1:0] held;
    } pmr_count_state_t;

    pmr_count_state_t st;
    pmr_count_state_t next_st;

    // Count samples, saturating, and hand the total over at each full cycle
    always_comb begin
        next_st = st;
        if (cycle_mark) begin
            next_st.held = st.run;
            next_st.run  = sample_tick ? CNT_W'(1) : '0;
        end else if (sample_tick && st.run != '1) begin
            next_st.run = st.run + CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.held;

endmodule : pmr_count

// ### pmr_result_regs.sv
`timescale 1ns/100ps
`include "pmr_regs.svh"

// Summary of operation
// - RMS voltage, unsigned 16-bit fraction, in bits 15:0 of first register.
// - RMS current, unsigned 16-bit fraction, in bits 31:16.
// - Active power, signed with 15 fraction bits, in bits 15:0 of second.
// - Reactive power, unsigned 16-bit fraction, in bits 31:16 of second register.
// - Apparent power magnitude, unsigned 16-bit fraction, bits 15:0 of third.
// - Power factor, signed 11-bit, 10 fraction bits, in bits 26:16 of third.
// - Bit 27 low when current leads, high when current lags.
// - Bit 28 low when generating power, high when consuming.
// - Sample count 0..1023 in bits 9:0, renewed each full voltage cycle.
// - First averaged RMS voltage in 15:0; zero when current averaging selected.
// - Averaged RMS current in 31:16 of both averages; zero unless selected.
// - Second averaged RMS voltage in 15:0; zero when current averaging selected.
// - Active power averaged over first length, bits 15:0 of own register.
// - Active power averaged over second length, bits 15:0 of own register.
// - Power codes scale to full-scale power 0.704; host multiplies by 1.42.

module pmr_result_regs
    import pmr_pkg::*;
#(
    parameter int AVG_LEN_W = `PMR_AVG_LEN_W,
    parameter int COUNT_W   = `PMR_COUNT_W
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // New results from the measurement engine
    input  wire logic                   meas_valid,
    input  wire logic [15:0]            rms_volts,
    input  wire logic [15:0]            rms_amps,
    input  wire logic [15:0]            real_power,
    input  wire logic [15:0]            reactive_power,
    input  wire logic [15:0]            apparent_power,
    input  wire logic [10:0]            power_ratio,
    input  wire logic                   angle_sign,
    input  wire logic                   ratio_sign,
    // Sample timing from the front end
    input  wire logic                   sample_tick,
    input  wire logic                   volt_cycle_mark,
    // Averaging configuration
    input  wire logic [AVG_LEN_W-1:0]   first_avg_length,
    input  wire logic [AVG_LEN_W-1:0]   second_avg_length,
    input  wire logic                   current_avg_select,
    // Register port from the serial interface
    input  wire logic                   reg_rd_en,
    input  wire logic                   reg_wr_en,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    output logic      [31:0]            reg_rdata,
    output logic                        reg_rd_valid,
    output logic                        reg_rd_miss,
    output logic                        reg_wr_dropped
);

    logic                 rst_meta;
    logic                 rst_sync;
    logic                 rst_n_int;
    pmr_top_state_t       st;
    pmr_top_state_t       next_st;
    pmr_avg_sel_t         avg_sel;
    logic [15:0]          rms_avg_in;
    logic [15:0]          rms_avg_first;
    logic [15:0]          rms_avg_second;
    logic [15:0]          real_avg_first;
    logic [15:0]          real_avg_second;
    logic [COUNT_W-1:0]   sample_count;
    logic [31:0]          word_rms;
    logic [31:0]          word_power;
    logic [31:0]          word_apparent;
    logic [31:0]          word_count;
    logic [31:0]          word_avg_first;
    logic [31:0]          word_avg_second;
    logic [31:0]          word_real_first;
    logic [31:0]          word_real_second;
    logic                 wdata_unused;

    // Reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign rst_n_int = rst_sync;

    // Write data has no destination in a read-only bank
    assign wdata_unused = ^reg_wdata;

    // RMS averagers follow the channel chosen by the select bit
    assign avg_sel    = current_avg_select ? PMR_AVG_AMPS : PMR_AVG_VOLTS;
    assign rms_avg_in = (avg_sel == PMR_AVG_AMPS) ? rms_amps : rms_volts;

    // First-length RMS average
    pmr_avg #(
        .DATA_W (16),
        .LEN_W  (AVG_LEN_W),
        .SIGNED (1'b0)
    ) u_rms_first (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n_int),
        .sample_en (meas_valid),
        .sample    (rms_avg_in),
        .avg_len   (first_avg_length),
        .avg       (rms_avg_first)
    );

    // Second-length RMS average
    pmr_avg #(
        .DATA_W (16),
        .LEN_W  (AVG_LEN_W),
        .SIGNED (1'b0)
    ) u_rms_second (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n_int),
        .sample_en (meas_valid),
        .sample    (rms_avg_in),
        .avg_len   (second_avg_length),
        .avg       (rms_avg_second)
    );

    // First-length active power average, signed
    pmr_avg #(
        .DATA_W (16),
        .LEN_W  (AVG_LEN_W),
        .SIGNED (1'b1)
    ) u_real_first (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n_int),
        .sample_en (meas_valid),
        .sample    (real_power),
        .avg_len   (first_avg_length),
        .avg       (real_avg_first)
    );

    // Second-length active power average, signed
    pmr_avg #(
        .DATA_W (16),
        .LEN_W  (AVG_LEN_W),
        .SIGNED (1'b1)
    ) u_real_second (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n_int),
        .sample_en (meas_valid),
        .sample    (real_power),
        .avg_len   (second_avg_length),
        .avg       (real_avg_second)
    );

    // Samples per full voltage cycle
    pmr_count #(
        .CNT_W (COUNT_W)
    ) u_count (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n_int),
        .sample_tick (sample_tick),
        .cycle_mark  (volt_cycle_mark),
        .count       (sample_count)
    );

    // Assemble the register words from the latched results
    always_comb begin
        word_rms   = `PMR_RESULT_RESET;
        word_power = `PMR_RESULT_RESET;
        word_rms[`PMR_LO_FIELD_LSB +: `PMR_HALF_W]   = st.rms_volts;
        word_rms[`PMR_HI_FIELD_LSB +: `PMR_HALF_W]   = st.rms_amps;
        // Codes are passed unscaled; full scale equals full_scale_power
        word_power[`PMR_LO_FIELD_LSB +: `PMR_HALF_W] = st.real_power;
        word_power[`PMR_HI_FIELD_LSB +: `PMR_HALF_W] = st.reactive_power;
    end

    // Apparent power, power factor and sign bits
    always_comb begin
        word_apparent = `PMR_RESULT_RESET;
        word_apparent[`PMR_LO_FIELD_LSB +: `PMR_HALF_W] = st.apparent_power;
        word_apparent[`PMR_RATIO_LSB +: `PMR_RATIO_W]   = st.power_ratio;
        word_apparent[`PMR_ANGLE_SIGN_BIT]              = st.angle_sign;
        word_apparent[`PMR_RATIO_SIGN_BIT]              = st.ratio_sign;
    end

    // Sample count word
    always_comb begin
        word_count = `PMR_RESULT_RESET;
        word_count[`PMR_COUNT_LSB +: COUNT_W] = sample_count;
    end

    // Averaged RMS words, each half zeroed when its channel is not selected
    always_comb begin
        word_avg_first  = `PMR_RESULT_RESET;
        word_avg_second = `PMR_RESULT_RESET;
        if (avg_sel == PMR_AVG_VOLTS) begin
            word_avg_first[`PMR_LO_FIELD_LSB +: `PMR_HALF_W]  = rms_avg_first;
            word_avg_second[`PMR_LO_FIELD_LSB +: `PMR_HALF_W] = rms_avg_second;
        end else begin
            word_avg_first[`PMR_HI_FIELD_LSB +: `PMR_HALF_W]  = rms_avg_first;
            word_avg_second[`PMR_HI_FIELD_LSB +: `PMR_HALF_W] = rms_avg_second;
        end
    end

    // Averaged active power words
    always_comb begin
        word_real_first  = `PMR_RESULT_RESET;
        word_real_second = `PMR_RESULT_RESET;
        word_real_first[`PMR_LO_FIELD_LSB +: `PMR_HALF_W]  = real_avg_first;
        word_real_second[`PMR_LO_FIELD_LSB +: `PMR_HALF_W] = real_avg_second;
    end

    // Latch results, answer reads, drop writes
    always_comb begin
        next_st            = st;
        next_st.rd_valid   = 1'b0;
        next_st.rd_miss    = 1'b0;
        next_st.wr_dropped = 1'b0;
        // Only the measurement engine refreshes the results
        if (meas_valid) begin
            next_st.rms_volts      = rms_volts;
            next_st.rms_amps       = rms_amps;
            next_st.real_power     = real_power;
            next_st.reactive_power = reactive_power;
            next_st.apparent_power = apparent_power;
            next_st.power_ratio    = power_ratio;
            next_st.angle_sign     = angle_sign;
            next_st.ratio_sign     = ratio_sign;
        end
        // Writes change nothing and are only reported, and only when no read comes in the same cycle
        if (reg_wr_en && !reg_rd_en) begin
            next_st.wr_dropped = 1'b1 ^ (wdata_unused & 1'b0);
        end
        // Read decode; unmapped addresses return zero
        if (reg_rd_en) begin
            next_st.rd_valid = 1'b1;
            unique case (reg_addr)
                `PMR_RMS_VOLTAGE_CURRENT: next_st.rd_data = word_rms;
                `PMR_ACTIVE_REACTIVE:     next_st.rd_data = word_power;
                `PMR_APPARENT_FACTOR:     next_st.rd_data = word_apparent;
                `PMR_RMS_SAMPLE_COUNT:    next_st.rd_data = word_count;
                `PMR_RMS_AVG_FIRST:       next_st.rd_data = word_avg_first;
                `PMR_RMS_AVG_SECOND:      next_st.rd_data = word_avg_second;
                `PMR_REAL_AVG_FIRST:      next_st.rd_data = word_real_first;
                `PMR_REAL_AVG_SECOND:     next_st.rd_data = word_real_second;
                default: begin
                    next_st.rd_data = `PMR_UNMAPPED_DATA;
                    next_st.rd_miss = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata      = st.rd_data;
    assign reg_rd_valid   = st.rd_valid;
    assign reg_rd_miss    = st.rd_miss;
    assign reg_wr_dropped = st.wr_dropped;

endmodule : pmr_result_regs

// ### pmr_result_regs_checker.sv
`timescale 1ns/100ps

module pmr_result_regs_checker (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Result inputs
    input wire logic        meas_valid,
    input wire logic [15:0] rms_volts,
    input wire logic [15:0] rms_amps,
    input wire logic [15:0] real_power,
    input wire logic [15:0] reactive_power,
    input wire logic [15:0] apparent_power,
    input wire logic [10:0] power_ratio,
    input wire logic        angle_sign,
    input wire logic        ratio_sign,
    // Register port
    input wire logic        reg_rd_en,
    input wire logic        reg_wr_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rd_valid,
    input wire logic        reg_rd_miss,
    input wire logic        reg_wr_dropped
);
    logic [31:0] w20;
    logic [31:0] w21;
    logic [31:0] w22;
    logic        mapped;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Addresses that decode to a result register
    assign mapped = reg_addr inside {8'h20, 8'h21, 8'h22, [8'h25:8'h29]};

    // Last result set, packed as the registers show it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w20 <= 32'h0000_0000;
            w21 <= 32'h0000_0000;
            w22 <= 32'h0000_0000;
        end else if (meas_valid) begin
            w20 <= {rms_amps, rms_volts};
            w21 <= {reactive_power, real_power};
            w22 <= {3'h0, ratio_sign, angle_sign, power_ratio, apparent_power};
        end
    end

    a_read_answered: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered next cycle");
    a_read_not_spurious: assert property (!reg_rd_en |=> !reg_rd_valid)
        else $error("answer without a read");
    a_unmapped_miss: assert property (reg_rd_en && !mapped |=> reg_rd_miss && reg_rdata == 0)
        else $error("unmapped read not flagged");
    a_mapped_hit: assert property (reg_rd_en && mapped |=> !reg_rd_miss)
        else $error("mapped read flagged as miss");
    a_write_dropped: assert property (reg_wr_en && !reg_rd_en |=> reg_wr_dropped)
        else $error("write not reported dropped");
    a_drop_only_write: assert property (!(reg_wr_en && !reg_rd_en) |=> !reg_wr_dropped)
        else $error("drop flag without a write");
    a_rdata_holds: assert property (!reg_rd_valid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_rms_word: assert property (
        reg_rd_en && reg_addr == 8'h20 && !meas_valid |=> reg_rdata == $past(w20))
        else $error("rms word wrong");
    a_power_word: assert property (
        reg_rd_en && reg_addr == 8'h21 && !meas_valid |=> reg_rdata == $past(w21))
        else $error("power word wrong");
    a_apparent_word: assert property (
        reg_rd_en && reg_addr == 8'h22 && !meas_valid |=> reg_rdata == $past(w22))
        else $error("apparent word wrong");
endmodule : pmr_result_regs_checker

// ### pmr_host.sv
`timescale 1ns/100ps

module pmr_host (
    // Clock
    input wire logic        ref_clk,
    // Register requests
    output logic            reg_rd_en,
    output logic            reg_wr_en,
    output logic [7:0]      reg_addr,
    output logic [31:0]     reg_wdata
);
    // Port idle at time zero
    initial begin
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
    end

    // One request, taken at the next edge; calling again gives back to back
    task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_rd_en <= rd;
        reg_wr_en <= !rd;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask : access

    // Release the port; stale address and data are scrambled, not held
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            reg_rd_en <= 1'b0;
            reg_wr_en <= 1'b0;
            reg_addr  <= ~reg_addr;
            reg_wdata <= ~reg_wdata;
        end
    endtask : idle
endmodule : pmr_host

// ### pmr_result_regs_tb.sv
`timescale 1ns/100ps

module pmr_result_regs_tb;
    import pmr_pkg::*;

    logic        ref_clk = 1'b0;
    logic        rst_n, meas_valid, angle_sign, ratio_sign;
    logic [15:0] rms_volts, rms_amps, real_power, reactive_power, apparent_power;
    logic [10:0] power_ratio;
    logic        sample_tick, volt_cycle_mark, current_avg_select;
    logic [6:0]  first_avg_length, second_avg_length;
    logic        reg_rd_en, reg_wr_en, reg_rd_valid, reg_rd_miss, reg_wr_dropped;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, e20, e21, e22;
    logic [32:0] exp_q[$];
    logic [32:0] want;
    logic [15:0] xs[4], ps[4], oth;
    logic [7:0]  regs[8] = '{8'h20, 8'h21, 8'h22, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29};
    int          lens[4] = '{1, 7, 1023, 1030};
    int          seed = 12214;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    int          drops = 0;
    int          m1, m2, pm1, pm2;

    pmr_result_regs pmr_result_regs_inst (.ref_clk, .rst_n, .meas_valid, .rms_volts,
        .rms_amps, .real_power, .reactive_power, .apparent_power, .power_ratio,
        .angle_sign, .ratio_sign, .sample_tick, .volt_cycle_mark, .first_avg_length,
        .second_avg_length, .current_avg_select, .reg_rd_en, .reg_wr_en, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_rd_miss, .reg_wr_dropped);

    pmr_host pmr_host_inst (.ref_clk, .reg_rd_en, .reg_wr_en, .reg_addr, .reg_wdata);

    // Clock
    always #25 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    // Note the expected answer, then issue the read
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic miss);
        exp_q.push_back({miss, exp});
        pmr_host_inst.access(1'b1, a, 32'h0000_0000);
    endtask : rd

    // One result set from the engine; side values random
    task automatic meas(input logic [15:0] v, input logic [15:0] a, input logic [15:0] p);
        logic [15:0] q, s;
        logic [15:0] r;
        q = 16'($random(seed));
        s = 16'($random(seed));
        r = 16'($random(seed));
        @(posedge ref_clk);
        meas_valid     <= 1'b1;
        rms_volts      <= v;
        rms_amps       <= a;
        real_power     <= p;
        reactive_power <= q;
        apparent_power <= s;
        power_ratio    <= r[10:0];
        angle_sign     <= r[11];
        ratio_sign     <= r[12];
        @(posedge ref_clk);
        meas_valid <= 1'b0;
        e20 = {a, v};
        e21 = {q, p};
        e22 = {3'h0, r[12], r[11], r[10:0], s};
    endtask : meas

    // n sample ticks, then one full voltage cycle mark
    task automatic cycle_of(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            sample_tick <= 1'b1;
        end
        @(posedge ref_clk);
        sample_tick     <= 1'b0;
        volt_cycle_mark <= 1'b1;
        @(posedge ref_clk);
        volt_cycle_mark <= 1'b0;
    endtask : cycle_of

    // Hang limit and answer checking against the oldest note
    always @(posedge ref_clk) begin
        cycles++;
        if (reg_rd_valid === 1'b1) begin
            want = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
            check("read word", {reg_rd_miss, reg_rdata}, want);
        end
        // Any non-low drop flag counts, so an unknown shows up as well
        if (reg_wr_dropped !== 1'b0) drops++;
        if (cycles == 4000) begin
            num_errors++;
            summarize();
        end
    end

    // Main sequence
    initial begin
        {rst_n, meas_valid, angle_sign, ratio_sign, power_ratio} = '0;
        {rms_volts, rms_amps, real_power, reactive_power, apparent_power} = '0;
        {sample_tick, volt_cycle_mark, current_avg_select} = '0;
        first_avg_length  = 7'h02;
        second_avg_length = 7'h04;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        pmr_host_inst.idle(3);
        foreach (regs[i]) rd(regs[i], 32'h0000_0000, 1'b0);
        rd(8'h23, 32'h0000_0000, 1'b1);
        pmr_host_inst.idle(1);
        // Averagers on voltage, then on current
        for (int ph = 0; ph < 2; ph++) begin
            @(posedge ref_clk);
            current_avg_select <= ph[0];
            first_avg_length   <= (ph == 1) ? 7'h00 : 7'h02;  // Zero acts as one
            foreach (xs[i]) begin
                xs[i] = 16'($random(seed));
                ps[i] = 16'($random(seed));
                oth   = 16'($random(seed));
                if (ph == 1) xs[i][15] = 1'b0;
                meas(ph == 1 ? oth : xs[i], ph == 1 ? xs[i] : oth, ps[i]);
            end
            m1  = (ph == 1) ? int'(xs[3]) : (int'(xs[2]) + int'(xs[3])) / 2;
            m2  = (int'(xs[0]) + int'(xs[1]) + int'(xs[2]) + int'(xs[3])) / 4;
            pm1 = (ph == 1) ? int'($signed(ps[3]))
                            : (int'($signed(ps[2])) + int'($signed(ps[3]))) / 2;
            pm2 = (int'($signed(ps[0])) + int'($signed(ps[1])) + int'($signed(ps[2]))
                   + int'($signed(ps[3]))) / 4;
            rd(8'h26, ph == 1 ? {m1[15:0], 16'h0000} : {16'h0000, m1[15:0]}, 1'b0);
            rd(8'h27, ph == 1 ? {m2[15:0], 16'h0000} : {16'h0000, m2[15:0]}, 1'b0);
            rd(8'h28, {16'h0000, pm1[15:0]}, 1'b0);
            rd(8'h29, {16'h0000, pm2[15:0]}, 1'b0);
            pmr_host_inst.idle(2);
        end
        // Latest results back to back, then a write that must not land
        rd(8'h20, e20, 1'b0);
        rd(8'h21, e21, 1'b0);
        rd(8'h22, e22, 1'b0);
        pmr_host_inst.access(1'b0, 8'h22, ~e22);
        rd(8'h22, e22, 1'b0);
        rd(8'h2a, 32'h0000_0000, 1'b1);
        pmr_host_inst.idle(1);
        // Samples per voltage cycle, up to and past saturation
        cycle_of(2);
        foreach (lens[i]) begin
            cycle_of(lens[i]);
            rd(8'h25, lens[i] > 1023 ? 32'h0000_03ff : 32'(lens[i]), 1'b0);
            pmr_host_inst.idle(1);
        end
        pmr_host_inst.idle(4);
        check("pending reads", 33'(exp_q.size()), 33'h0_0000_0000);
        check("write drops", 33'(drops), 33'h0_0000_0001);
        summarize();
    end
endmodule : pmr_result_regs_tb

bind pmr_result_regs pmr_result_regs_checker pmr_result_regs_checker_inst (.ref_clk, .rst_n,
    .meas_valid, .rms_volts, .rms_amps, .real_power, .reactive_power, .apparent_power,
    .power_ratio, .angle_sign, .ratio_sign, .reg_rd_en, .reg_wr_en, .reg_addr, .reg_rdata,
    .reg_rd_valid, .reg_rd_miss, .reg_wr_dropped);
